// ### design/spw_serial_port.sv
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "spw_defs.svh"
// Notes on behaviour
// - enable bit claims pins; clear disables
// - stop-in-idle halts module while cpu idles
// - element count: master pending, slave unread
// - shift-register-empty flag in enhanced mode
// - receive into full buffer discards, sets overflow
// - receive fifo empty flag in enhanced mode
// - transmit-side event select codes 111..100
// - receive-side event select codes 011..000
// - transmit full: write sets, slot frees clears
// - receive full: fill sets, read clears
// - clock-pin disable releases master clock pin
// - data-out disable releases data pin
// - word select: 16 bits, else 8
// - sample phase: end or middle of bit in master, middle in slave
// - clock edge bit selects data change edge
// - slave select pin used only when enabled
// - clock polarity sets idle and active levels
// - master enable: generate clock, else slave
// - secondary and primary prescaler codes
// - framed: sync pin direction by bit
// - sync polarity; coincide or precede first clock
// - enhanced bit selects eight-entry fifo
// - master starts when buffer is written
// - enhanced mode buffers eight entries deep
// - clock rate is core over prescale product, with 1:1 run as 2:1
module spw_serial_port (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cpu_idle,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic buf_event,
  input wire logic serial_clock_pin,
  output logic serial_clock_drive,
  output logic serial_clock_oe,
  output logic serial_data_out_pin,
  output logic serial_data_out_oe,
  input wire logic serial_data_in_pin,
  input wire logic slave_select_pin,
  output logic slave_select_drive,
  output logic slave_select_oe
);
  function automatic logic [3:0] cnt_nx(logic [3:0] c, logic inc, logic dec);
    return 4'(c + {3'h0, inc} - {3'h0, dec});
  endfunction

  logic [2:0] sy1_q, sy2_q;
  logic sck_prev_q;
  logic en_q, sidl_q, rov_q, frm_q, fsd_q, fpol_q, fe_q, ben_q;
  logic [2:0] buffer_irq_select_q;
  logic [12:0] con1_q;
  logic [15:0] txm [8];
  logic [15:0] rxm [8];
  logic [2:0] twp_q, trp_q, rwp_q, rrp_q;
  logic [3:0] tcnt_q, rcnt_q;
  spw_pkg::spw_state_t st_q;
  logic [5:0] t_q;
  logic [9:0] div_q;
  logic [15:0] sh_q, rs_q;
  logic lvl_q, pend_q, fs_q, sld_q;

  // pins are asynchronous to core_clk
  wire sck_s = sy2_q[0];
  wire sdi_s = sy2_q[1];
  wire ss_s = sy2_q[2];

  wire ckdis = con1_q[`SPW_B_CKDIS];
  wire dodis = con1_q[`SPW_B_DODIS];
  wire word = con1_q[`SPW_B_WORD];
  wire sph = con1_q[`SPW_B_SPH];
  wire cke = con1_q[`SPW_B_CKEDGE];
  wire slave_select_enable = con1_q[`SPW_B_SLAVE_SELECT_ENABLE];
  wire cpol = con1_q[`SPW_B_CPOL];
  wire mst = con1_q[`SPW_B_MST];
  wire [2:0] psec = con1_q[`SPW_F_PSEC];
  wire [1:0] ppri = con1_q[`SPW_F_PPRI];

  wire run = en_q & ~(sidl_q & cpu_idle);
  wire [5:0] nbits = word ? `SPW_BITS_WORD : `SPW_BITS_BYTE;
  wire [3:0] lim = ben_q ? `SPW_DEPTH : `SPW_STD_DEPTH;
  wire tfull = tcnt_q == lim;
  wire rfull = rcnt_q == lim;

  wire wr_stat = reg_wr & (reg_addr == `SPW_OFF_STAT);
  wire wr_con1 = reg_wr & (reg_addr == `SPW_OFF_CON1);
  wire wr_con2 = reg_wr & (reg_addr == `SPW_OFF_CON2);
  wire wr_buf = reg_wr & (reg_addr == `SPW_OFF_BUF);
  wire rd_buf = reg_rd & (reg_addr == `SPW_OFF_BUF);

  // prescale: secondary 8-code, primary 4^(3-code)
  wire [3:0] sec_r = 4'(4'h8 - {1'b0, psec});
  wire [6:0] pri_r = 7'h01 << {~ppri, 1'b0};
  wire [9:0] ratio_raw = 10'({6'h00, sec_r} * {3'h0, pri_r});
  // 1:1 cannot make two edges per period, so run it as 2:1
  wire [9:0] ratio = (ratio_raw < `SPW_MIN_RATIO) ? `SPW_MIN_RATIO
                                                   : ratio_raw;
  wire [9:0] half_lo = ratio >> 1;
  wire [9:0] half_hi = 10'(ratio - half_lo);
  wire tick = (div_q == 10'h000) & run;

  // master sequencing on half-period ticks
  wire m_idle = st_q == spw_pkg::SPW_IDLE;
  wire fs_in_ok = ~frm_q | ~fsd_q | (ss_s == fpol_q);
  wire m_start = mst & m_idle & run & (tcnt_q != 4'h0) & fs_in_ok;
  wire m_tick = mst & tick & (st_q == spw_pkg::SPW_SHIFT);
  wire m_edge = t_q < {nbits[4:0], 1'b0};
  wire m_mid = m_tick & m_edge & (t_q[0] ^ cke);
  wire m_chg = m_tick & m_edge & ~(t_q[0] ^ cke) & (t_q != 6'h00);
  wire m_samp = sph ? (m_tick & pend_q) : m_mid;
  wire m_done = m_tick & (t_q == {nbits[4:0], 1'b0});

  // slave sequencing on synchronised clock edges
  wire s_lvl = sck_s ^ cpol;
  wire p_lvl = sck_prev_q ^ cpol;
  wire lead = s_lvl & ~p_lvl;
  wire trail = ~s_lvl & p_lvl;
  wire s_desel = ~frm_q & slave_select_enable & ss_s;
  wire s_frm_ok = ~fsd_q | (ss_s == fpol_q) | (t_q != 6'h00);
  wire s_ok = ~mst & run & (frm_q ? s_frm_ok : ~s_desel);
  wire s_mid = s_ok & (cke ? lead : trail);
  wire s_chg = s_ok & (cke ? trail : lead) & (t_q != 6'h00);
  wire s_done = s_mid & (t_q == 6'(nbits - 6'h01));
  wire s_load = ~mst & run & ~sld_q & (t_q == 6'h00) & (tcnt_q != 4'h0);

  wire samp = mst ? m_samp : s_mid;
  wire chg = mst ? m_chg : s_chg;
  wire done = mst ? m_done : s_done;
  wire load = m_start | s_load;

  wire [15:0] tx_head = txm[trp_q];
  wire [15:0] ld_word = word ? tx_head : {tx_head[7:0], 8'h00};
  wire [15:0] rx_raw = mst ? rs_q : {rs_q[14:0], sdi_s};
  wire [15:0] rx_word = word ? rx_raw : {8'h00, rx_raw[7:0]};

  wire push_tx = wr_buf & en_q & ~tfull;
  wire pop_tx = load;
  wire ovf = done & rfull;
  wire push_rx = done & ~rfull;
  wire pop_rx = rd_buf & (rcnt_q != 4'h0);
  wire [3:0] tcnt_d = cnt_nx(tcnt_q, push_tx, pop_tx);
  wire [3:0] rcnt_d = cnt_nx(rcnt_q, push_rx, pop_rx);

  wire busy = mst ? ~m_idle : ((t_q != 6'h00) | sld_q);
  wire stat_shift_reg_empty = ben_q & ~busy;
  wire stat_rxmpt = ben_q & (rcnt_q == 4'h0);
  // a full count of eight wraps to zero in three bits
  wire [2:0] bec = mst ? tcnt_q[2:0] : rcnt_q[2:0];
  wire [15:0] stat_rd = {en_q, 1'b0, sidl_q, 2'b00, bec, stat_shift_reg_empty,
                         rov_q, stat_rxmpt, buffer_irq_select_q, tfull, rfull};
  wire [15:0] con2_rd = {frm_q, fsd_q, fpol_q, 11'h000, fe_q, ben_q};
  wire [15:0] rd_mux = (reg_addr == `SPW_OFF_STAT) ? stat_rd :
                       (reg_addr == `SPW_OFF_CON1) ? {3'h0, con1_q} :
                       (reg_addr == `SPW_OFF_CON2) ? con2_rd : rxm[rrp_q];

  logic ev_sel;
  always_comb
  begin
    unique case (buffer_irq_select_q)
      3'h7: ev_sel = (tcnt_d == lim) & ~tfull;
      3'h6: ev_sel = pop_tx & (tcnt_d == 4'h0);
      3'h5: ev_sel = done & (tcnt_d == 4'h0);
      3'h4: ev_sel = pop_tx;
      3'h3: ev_sel = (rcnt_d == lim) & ~rfull;
      3'h2: ev_sel = (rcnt_d >= `SPW_THREEQ) & (rcnt_q < `SPW_THREEQ);
      3'h1: ev_sel = push_rx;
      3'h0: ev_sel = pop_rx & (rcnt_d == 4'h0);
    endcase
  end
  wire ev = en_q & (ben_q ? ev_sel : done);

  // pin drivers, registered
  wire fs_act = mst ? fs_q : ((t_q == 6'h00) & sld_q);
  wire sck_oe_d = en_q & mst & ~ckdis;
  wire sdo_oe_d = en_q & ~dodis & (mst | ~s_desel);
  wire ss_oe_d = en_q & frm_q & ~fsd_q;
  wire ss_d = fs_act ? fpol_q : ~fpol_q;

  always_ff @(posedge core_clk)
  begin
    sy1_q <= {slave_select_pin, serial_data_in_pin, serial_clock_pin};
    sy2_q <= sy1_q;
    sck_prev_q <= sy2_q[0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 16'h0000;
      buf_event <= 1'b0;
      serial_clock_drive <= 1'b0;
      serial_clock_oe <= 1'b0;
      serial_data_out_pin <= 1'b0;
      serial_data_out_oe <= 1'b0;
      slave_select_drive <= 1'b0;
      slave_select_oe <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      buf_event <= ev;
      serial_clock_drive <= cpol ^ lvl_q;
      serial_clock_oe <= sck_oe_d;
      serial_data_out_pin <= sh_q[15];
      serial_data_out_oe <= sdo_oe_d;
      slave_select_drive <= ss_d;
      slave_select_oe <= ss_oe_d;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      en_q <= 1'b0;
      sidl_q <= 1'b0;
      buffer_irq_select_q <= 3'h0;
      con1_q <= `SPW_RST_CON1;
      {frm_q, fsd_q, fpol_q, fe_q, ben_q} <= 5'h00;
    end
    else
    begin
      if (wr_stat)
      begin
        en_q <= reg_wdata[`SPW_B_EN];
        sidl_q <= reg_wdata[`SPW_B_SIDL];
        buffer_irq_select_q <= reg_wdata[`SPW_F_BUFFER_IRQ_SELECT];
      end
      if (wr_con1)
        con1_q <= reg_wdata[12:0];
      if (wr_con2)
        {frm_q, fsd_q, fpol_q, fe_q, ben_q} <= {reg_wdata[15:13],
                                                reg_wdata[1:0]};
    end
  end

  // overflow sets win over a software clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rov_q <= 1'b0;
    else
      rov_q <= ovf | (rov_q & ~(wr_stat & ~reg_wdata[`SPW_B_ROV]));
  end

  always_ff @(posedge core_clk)
  begin
    if (push_tx)
      txm[twp_q] <= reg_wdata;
    if (push_rx)
      rxm[rwp_q] <= rx_word;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !en_q)
    begin
      {twp_q, trp_q, rwp_q, rrp_q} <= 12'h000;
      tcnt_q <= 4'h0;
      rcnt_q <= 4'h0;
    end
    else
    begin
      twp_q <= push_tx ? 3'(twp_q + 3'h1) : twp_q;
      trp_q <= pop_tx ? 3'(trp_q + 3'h1) : trp_q;
      rwp_q <= push_rx ? 3'(rwp_q + 3'h1) : rwp_q;
      rrp_q <= pop_rx ? 3'(rrp_q + 3'h1) : rrp_q;
      tcnt_q <= tcnt_d;
      rcnt_q <= rcnt_d;
    end
  end

  // half-period divider, reloaded per clock phase
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || m_idle)
      div_q <= 10'(half_lo - 10'h001);
    else if (tick)
      div_q <= 10'((lvl_q ? half_lo : half_hi) - 10'h001);
    else if (run)
      div_q <= 10'(div_q - 10'h001);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !en_q)
    begin
      st_q <= spw_pkg::SPW_IDLE;
      t_q <= 6'h00;
      lvl_q <= 1'b0;
      pend_q <= 1'b0;
      fs_q <= 1'b0;
      sld_q <= 1'b0;
      sh_q <= 16'h0000;
      rs_q <= 16'h0000;
    end
    else
    begin
      if (load)
        sh_q <= ld_word;
      else if (chg)
        sh_q <= {sh_q[14:0], 1'b0};
      if (samp)
        rs_q <= {rs_q[14:0], sdi_s};
      if (m_start)
      begin
        t_q <= 6'h00;
        fs_q <= frm_q & ~fsd_q;
        st_q <= (frm_q & ~fsd_q & ~fe_q) ? spw_pkg::SPW_SYNC
                                         : spw_pkg::SPW_SHIFT;
      end
      else if (mst & tick & (st_q == spw_pkg::SPW_SYNC))
      begin
        // sync held a full clock period before the first bit
        t_q <= (t_q == 6'h01) ? 6'h00 : 6'(t_q + 6'h01);
        fs_q <= t_q != 6'h01;
        if (t_q == 6'h01)
          st_q <= spw_pkg::SPW_SHIFT;
      end
      else if (m_tick)
      begin
        pend_q <= m_mid;
        if (m_edge)
          lvl_q <= ~lvl_q;
        if (t_q == 6'h01)
          fs_q <= 1'b0;
        t_q <= m_done ? 6'h00 : 6'(t_q + 6'h01);
        if (m_done)
          st_q <= spw_pkg::SPW_IDLE;
      end
      else if (~mst)
      begin
        st_q <= spw_pkg::SPW_IDLE;
        lvl_q <= 1'b0;
        if (s_load)
          sld_q <= 1'b1;
        else if (s_done)
          sld_q <= 1'b0;
        if (s_desel | s_done)
          t_q <= 6'h00;
        else if (s_mid)
          t_q <= 6'(t_q + 6'h01);
      end
    end
  end

  // checks
  default clocking chk_clk @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic [5:0] hc_q;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || m_start)
      hc_q <= 6'h00;
    else if (m_tick & m_edge)
      hc_q <= 6'(hc_q + 6'h01);
  end

  chk_ovf_sets_flag: assert property (ovf |=> rov_q)
    else $error("overflow flag not set");
  chk_ovf_discards: assert property ((ovf & ~pop_rx) |=>
    rcnt_q == $past(rcnt_q))
    else $error("overflow data was stored");
  chk_off_pins: assert property (!en_q |=> !serial_clock_oe &&
    !serial_data_out_oe && !slave_select_oe)
    else $error("pins driven while disabled");
  chk_idle_halt: assert property ((!run && m_idle) |=> m_idle)
    else $error("transfer started while halted");
  chk_sck_idle: assert property ((m_idle && $past(m_idle) &&
    $stable(cpol)) |-> serial_clock_drive == cpol)
    else $error("clock not at idle level");
  chk_edge_count: assert property (m_done |->
    hc_q == {nbits[4:0], 1'b0})
    else $error("wrong number of clock edges");
  chk_write_start: assert property ((m_idle && mst && run &&
    tcnt_q != 4'h0 && !frm_q) |=> !m_idle)
    else $error("master did not start");
  chk_std_read: assert property ((!ben_q && pop_rx) |=>
    rcnt_q == 4'h0 && !stat_rd[0])
    else $error("receive full not cleared");
  chk_fifo_bound: assert property (tcnt_q <= lim && rcnt_q <= lim)
    else $error("fifo count beyond depth");
  chk_msb_out: assert property ((load && !chg) ##1 !chg |->
    ##1 serial_data_out_pin == $past(ld_word[15], 2))
    else $error("first bit is not the msb");
  chk_sync_precede: assert property ((st_q == spw_pkg::SPW_SYNC) |->
    fs_q && serial_clock_drive == cpol)
    else $error("sync not ahead of clock");

  cov_master_word: cover property (m_done && word);
  cov_slave_byte: cover property (s_done && !word);
  cov_overflow: cover property (ovf);
  cov_frame_pre: cover property (st_q == spw_pkg::SPW_SYNC ##1
    st_q == spw_pkg::SPW_SHIFT);
endmodule

// ### design/spw_defs.svh
`ifndef SPW_DEFS_SVH
`define SPW_DEFS_SVH
`define SPW_OFF_STAT 2'h0
`define SPW_OFF_CON1 2'h1
`define SPW_OFF_CON2 2'h2
`define SPW_OFF_BUF 2'h3
`define SPW_B_EN 15
`define SPW_B_SIDL 13
`define SPW_B_ROV 6
`define SPW_F_BUFFER_IRQ_SELECT 4:2
`define SPW_F_PSEC 4:2
`define SPW_F_PPRI 1:0
`define SPW_B_CKDIS 12
`define SPW_B_DODIS 11
`define SPW_B_WORD 10
`define SPW_B_SPH 9
`define SPW_B_CKEDGE 8
`define SPW_B_SLAVE_SELECT_ENABLE 7
`define SPW_B_CPOL 6
`define SPW_B_MST 5
`define SPW_B_FRM 15
`define SPW_B_FSDIR 14
`define SPW_B_FSPOL 13
`define SPW_B_FSEDGE 1
`define SPW_B_EBUF 0
`define SPW_RST_CON1 13'h0000
`define SPW_DEPTH 4'h8
`define SPW_STD_DEPTH 4'h1
`define SPW_THREEQ 4'h6
`define SPW_BITS_WORD 6'h10
`define SPW_BITS_BYTE 6'h08
`define SPW_MIN_RATIO 10'h002
`endif

// ### design/spw_pkg.sv
package spw_pkg;
  typedef enum logic [1:0] {SPW_IDLE, SPW_SYNC, SPW_SHIFT} spw_state_t;
endpackage

// ### testbench/spw_slave_model.sv
`timescale 1ns/10ps
module spw_slave_model (
  input wire logic sck,
  input wire logic cpol,
  input wire logic word,
  input wire logic sdo,
  output logic sdi
);
  // loopback slave: each reply is the word shifted in on the transfer before
  logic [15:0] sr = 16'h5A3C;
  logic sample_phase = 1'b0;
  wire act = sck ^ cpol;
  // capture on idle-to-active; the port changes data on the other edge
  always @(posedge act) sample_phase = sdo;
  always @(negedge act) sr = {sr[14:0], sample_phase};
  assign sdi = word ? sr[15] : sr[7];
endmodule

// ### testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic core_clk, rst_n, reg_wr, reg_rd, sdi, cpol, word;
  logic [1:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, st, got, prev, d;
  logic [15:0] q [3];
  logic [31:0] seed;
  logic sck_d, sck_oe, sdo, sdo_oe, ss_d, ss_oe, ev, idle;
  int failures, comparisons, i, evn;
  time t0;

  spw_serial_port u_spw_serial_port (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cpu_idle(idle),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .buf_event(ev),
    .serial_clock_pin(sck_d),
    .serial_clock_drive(sck_d),
    .serial_clock_oe(sck_oe),
    .serial_data_out_pin(sdo),
    .serial_data_out_oe(sdo_oe),
    .serial_data_in_pin(sdi),
    .slave_select_pin(1'b1),
    .slave_select_drive(ss_d),
    .slave_select_oe(ss_oe)
  );

  spw_slave_model u_spw_slave_model (
    .sck(sck_d),
    .cpol(cpol),
    .word(word),
    .sdo(sdo),
    .sdi(sdi)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // standard mode pulses once per finished transfer
  initial
    evn = 0;
  always @(posedge core_clk)
    if (ev === 1'b1)
      evn++;

  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // bounded wait on status; a miss shows up in the caller's compare
  task automatic poll(input logic [15:0] m, input logic [15:0] v);
    int k;
    for (k = 0; k < 2000; k++)
    begin
      rd(2'h0, st);
      if ((st & m) === v)
        break;
    end
  endtask

  task automatic settle();
    repeat (3) @(negedge core_clk);
  endtask

  task automatic xfer(input logic [15:0] v, input logic meas);
    logic [15:0] m;
    m = word ? 16'hFFFF : 16'h00FF;
    wr(2'h3, v);
    if (meas)
    begin
      @(posedge sck_d);
      t0 = $time;
      @(posedge sck_d);
      chk_word(16'(($time - t0) / 100), 16'h0008);
    end
    poll(16'h0001, 16'h0001);
    chk_bit(st[0], 1'b1);
    rd(2'h3, got);
    chk_word(got, prev & m);
    prev = word ? v : {prev[7:0], v[7:0]};
    rd(2'h0, st);
    chk_bit(st[0], 1'b0);
  endtask

  task give_verdict();
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #6000000;
    failures++;
    give_verdict();
  end

  initial
  begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 16'h0000;
    cpol = 1'b0;
    word = 1'b0;
    idle = 1'b0;
    failures = 0;
    comparisons = 0;
    seed = 32'd93525;
    prev = 16'h5A3C;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      rd(i[1:0], got);
      chk_word(got, 16'h0000);
    end
    // master, clock edge 1, prescale 4 x 2
    wr(2'h1, 16'h013A);
    wr(2'h0, 16'h8000);
    settle();
    chk_bit(sck_oe, 1'b1);
    chk_bit(sdo_oe, 1'b1);
    chk_bit(sck_d, 1'b0);
    for (i = 0; i < 8; i++)
    begin
      word = i[0];
      wr(2'h1, word ? 16'h053A : 16'h013A);
      d = (i == 1) ? 16'h8001 : ((i == 2) ? 16'h7FFE : xs());
      xfer(d, i == 0);
    end
    // second word lands while the first is unread
    d = xs();
    wr(2'h3, d);
    poll(16'h0001, 16'h0001);
    wr(2'h3, ~d);
    poll(16'h0040, 16'h0040);
    chk_bit(st[6], 1'b1);
    chk_word(16'(evn), 16'h000A);
    rd(2'h3, got);
    chk_word(got, prev);
    prev = ~d;
    wr(2'h0, 16'h8000);
    rd(2'h0, st);
    chk_bit(st[6], 1'b0);
    wr(2'h0, 16'h0000);
    wr(2'h2, 16'h0001);
    wr(2'h0, 16'h8000);
    rd(2'h0, st);
    chk_bit(st[5], 1'b1);
    for (i = 0; i < 3; i++)
    begin
      q[i] = xs();
      wr(2'h3, q[i]);
    end
    poll(16'h07A0, 16'h0080);
    chk_word(st & 16'h07A0, 16'h0080);
    for (i = 0; i < 3; i++)
    begin
      rd(2'h3, got);
      chk_word(got, (i == 0) ? prev : q[i - 1]);
    end
    rd(2'h0, st);
    chk_bit(st[5], 1'b1);
    // halted while idle: the queued word must wait
    wr(2'h0, 16'hA000);
    idle <= 1'b1;
    wr(2'h3, xs());
    settle();
    rd(2'h0, st);
    chk_word(st & 16'h0780, 16'h0180);
    @(posedge core_clk);
    idle <= 1'b0;
    poll(16'h0780, 16'h0080);
    chk_word(st & 16'h0780, 16'h0080);
    // slowest prescale keeps the fifo from draining while it is filled
    wr(2'h1, 16'h0520);
    for (i = 0; i < 9; i++)
      wr(2'h3, xs());
    rd(2'h0, st);
    chk_bit(st[1], 1'b1);
    chk_word(st & 16'h0700, 16'h0000);
    wr(2'h0, 16'h0000);
    cpol = 1'b1;
    wr(2'h1, 16'h1860);
    wr(2'h0, 16'h8000);
    settle();
    chk_bit(sck_oe, 1'b0);
    chk_bit(sdo_oe, 1'b0);
    wr(2'h1, 16'h0060);
    settle();
    chk_bit(sck_oe, 1'b1);
    chk_bit(sck_d, 1'b1);
    wr(2'h2, 16'h8000);
    settle();
    chk_bit(ss_oe, 1'b1);
    chk_bit(ss_d, 1'b1);
    wr(2'h2, 16'hC000);
    settle();
    chk_bit(ss_oe, 1'b0);
    give_verdict();
  end
endmodule
